// ### mpwm_pkg.sv
package mpwm_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  // Register map, word index
  localparam logic [3:0] ADDR_UNIT_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_PRESCALE   = 4'h1;
  localparam logic [3:0] ADDR_MODE_M     = 4'h2;
  localparam logic [3:0] ADDR_MODE_S1    = 4'h3;
  localparam logic [3:0] ADDR_MODE_S2    = 4'h4;
  localparam logic [3:0] ADDR_PERIOD     = 4'h5;
  localparam logic [3:0] ADDR_DUTY1      = 4'h6;
  localparam logic [3:0] ADDR_DUTY2      = 4'h7;
  localparam logic [3:0] ADDR_OUT_CTRL   = 4'h8;
  localparam logic [3:0] ADDR_START      = 4'h9;
  localparam logic [3:0] ADDR_STOP       = 4'hA;
  localparam logic [3:0] ADDR_STATUS     = 4'hB;
  localparam logic [3:0] ADDR_CNT_M      = 4'hC;
  localparam logic [3:0] ADDR_CNT_S1     = 4'hD;
  localparam logic [3:0] ADDR_CNT_S2     = 4'hE;
  // Mode register fields
  localparam int MODE_MD0_BIT    = 0;
  localparam int MODE_MD_LSB     = 1;
  localparam int MODE_CIS_LSB    = 6;
  localparam int MODE_STS_LSB    = 8;
  localparam int MODE_MASTER_BIT = 11;
  localparam int MODE_CCS_BIT    = 12;
  localparam int MODE_CKS_LSB    = 14;
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [1:0] CKS_CLK0      = 2'h0;
  localparam logic [1:0] CKS_CLK1      = 2'h2;
  // Output control fields: value[2:0], enable[6:4], level[10:8], mode[14:12]
  localparam int OUT_VAL_LSB = 0;
  localparam int OUT_EN_LSB  = 4;
  localparam int OUT_LVL_LSB = 8;
  localparam int OUT_MOD_LSB = 12;
  localparam logic [15:0] MODE_RESET   = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'h0000;
  localparam logic [15:0] ZERO16       = 16'h0000;
endpackage

// ### mpwm_tick_if.sv
`timescale 1ns/1ps
interface mpwm_tick_if;
  logic tick0;
  logic tick1;
  modport src (output tick0, output tick1);
  modport dst (input tick0, input tick1);
endinterface

// ### mpwm_prescaler.sv
`timescale 1ns/1ps
module mpwm_prescaler (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic [3:0] sel0,
  input  wire logic [3:0] sel1,
  mpwm_tick_if.src        ticks
);
  import mpwm_pkg::*;
  logic [15:0] div_ff;

  function automatic logic tap(input logic [15:0] cnt, input logic [3:0] sel);
    logic [15:0] mask;
    mask = (16'h0001 << sel) - 16'h0001;
    return (cnt & mask) == mask;
  endfunction

  always_ff @(posedge clock) begin
    if (reset || !enable) begin
      div_ff <= ZERO16;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end

  // Two shared rates, divide by 2^sel
  assign ticks.tick0 = enable && tap(div_ff, sel0);
  assign ticks.tick1 = enable && tap(div_ff, sel1);
endmodule

// ### mpwm_slave.sv
`timescale 1ns/1ps
module mpwm_slave #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             running,
  input  wire logic             tick,
  input  wire logic             trigger,
  input  wire logic [WIDTH-1:0] duty,
  input  wire logic [WIDTH-1:0] period,
  output logic      [WIDTH-1:0] count,
  output logic                  irq,
  output logic                  active,
  output logic                  busy
);
  import mpwm_pkg::*;
  logic             pend_ff;
  logic             full_ff;
  logic [WIDTH:0]   per_p1;

  if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
    $error("WIDTH out of range");
  end

  assign per_p1 = {1'b0, period} + {{WIDTH{1'b0}}, 1'b1};

  always_ff @(posedge clock) begin
    if (reset || !running) begin
      pend_ff <= 1'b0;
    end else if (trigger) begin
      pend_ff <= 1'b1;
    end else if (tick) begin
      pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    irq <= 1'b0;
    if (reset) begin
      count  <= '0;
      busy   <= 1'b0;
      active <= 1'b0;
      full_ff <= 1'b0;
    end else if (running && tick) begin
      if (pend_ff) begin
        count   <= duty;
        busy    <= (duty != '0);
        active  <= (duty != '0);
        full_ff <= ({1'b0, duty} > per_p1);
      end else if (busy) begin
        if (count == '0 || count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
          count  <= '0;
          busy   <= 1'b0;
          irq    <= 1'b1;
          active <= full_ff;
        end else begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// ### mpwm_top.sv
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module mpwm_top #(
  parameter int WIDTH = 16
) (
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic [mpwm_pkg::ADDR_W-1:0] addr,
  input  wire logic [15:0]                 wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [15:0]                 rdata,
  output logic                             master_output_pin,
  output logic                             slave_one_output_pin,
  output logic                             slave_two_output_pin,
  output logic                             master_period_irq,
  output logic                             slave_one_irq,
  output logic                             slave_two_irq
);
  import mpwm_pkg::*;

  if (WIDTH != 16) begin : g_width_check
    $error("WIDTH must be 16");
  end

  logic        unit_clock_enable_ff;
  logic [7:0]  clock_prescaler_select_ff;
  logic [15:0] mode_m_ff;
  logic [15:0] mode_s1_ff;
  logic [15:0] mode_s2_ff;
  logic [15:0] period_reload_value_ff;
  logic [15:0] duty_reload_one_ff;
  logic [15:0] duty_reload_two_ff;
  logic [2:0]  out_val;
  logic        pin_m_ff;
  logic        pin_s1_ff;
  logic        pin_s2_ff;
  logic [2:0]  out_en_ff;
  logic [2:0]  out_lvl_ff;
  logic [2:0]  out_mod_ff;
  logic        running_ff;
  logic        start_pend_ff;
  logic [15:0] master_counter_ff;
  logic        wr_ok;
  logic        start_req;
  logic        stop_req;
  logic        tick_m;
  logic        tick_s1;
  logic        tick_s2;
  logic [15:0] slave_counter_one;
  logic [15:0] slave_counter_two;
  logic        act1;
  logic        act2;
  logic        busy1;
  logic        busy2;
  logic        s1_irq;
  logic        s2_irq;
  logic        m_irq;
  logic        master_step;
  logic        wr_unit_ctrl;
  logic        wr_out_ctrl;
  logic [2:0]  channel_enable_status;
  logic [15:0] rd_mux;

  mpwm_tick_if ticks ();

  function automatic logic sel_tick(input logic [15:0] mode, input logic t0, input logic t1);
    logic [1:0] cks;
    cks = mode[MODE_CKS_LSB +: 2];
    if (mode[MODE_CCS_BIT]) begin
      return 1'b0;
    end
    case (cks)
      CKS_CLK0: return t0;
      CKS_CLK1: return t1;
      default:  return 1'b0;
    endcase
  endfunction

  function automatic logic out_level(input logic act, input logic inv);
    return act ^ inv;
  endfunction

  function automatic logic reg_write(input logic ok, input logic [3:0] a, input logic [3:0] target);
    return ok && (a == target);
  endfunction

  assign wr_ok        = wr_en && unit_clock_enable_ff;
  assign wr_unit_ctrl = reg_write(wr_en, addr, ADDR_UNIT_CTRL);
  assign wr_out_ctrl  = reg_write(wr_ok, addr, ADDR_OUT_CTRL);
  assign start_req    = reg_write(wr_ok, addr, ADDR_START) && wdata[0];
  assign stop_req     = reg_write(wr_ok, addr, ADDR_STOP) && wdata[0];

  mpwm_prescaler u_prescaler (
    .clock  (clock),
    .reset  (reset),
    .enable (unit_clock_enable_ff),
    .sel0   (clock_prescaler_select_ff[3:0]),
    .sel1   (clock_prescaler_select_ff[7:4]),
    .ticks  (ticks.src)
  );

  assign tick_m  = sel_tick(mode_m_ff, ticks.tick0, ticks.tick1);
  assign tick_s1 = sel_tick(mode_s1_ff, ticks.tick0, ticks.tick1);
  assign tick_s2 = sel_tick(mode_s2_ff, ticks.tick0, ticks.tick1);
  assign master_step = running_ff && tick_m && (mode_m_ff[MODE_MD_LSB +: 3] == MODE_INTERVAL);

  // Unit clock gate, always writable
  always_ff @(posedge clock) begin
    if (reset) begin
      unit_clock_enable_ff <= 1'b0;
    end else if (wr_unit_ctrl) begin
      unit_clock_enable_ff <= wdata[0];
    end
  end

  // Configuration registers
  always_ff @(posedge clock) begin
    if (reset) begin
      clock_prescaler_select_ff <= 8'h00;
      mode_m_ff                 <= MODE_RESET;
      mode_s1_ff                <= MODE_RESET;
      mode_s2_ff                <= MODE_RESET;
    end else if (wr_ok) begin
      case (addr)
        ADDR_PRESCALE: clock_prescaler_select_ff <= wdata[7:0];
        ADDR_MODE_M: begin
          mode_m_ff <= wdata;
        end
        ADDR_MODE_S1: begin
          if (!running_ff) mode_s1_ff <= wdata;
        end
        ADDR_MODE_S2: begin
          if (!running_ff) mode_s2_ff <= wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Reload registers, rewritable at any time while the unit clock is on
  always_ff @(posedge clock) begin
    if (reset) begin
      period_reload_value_ff <= PERIOD_RESET;
      duty_reload_one_ff     <= ZERO16;
      duty_reload_two_ff     <= ZERO16;
    end else if (wr_ok) begin
      case (addr)
        ADDR_PERIOD: period_reload_value_ff <= wdata;
        ADDR_DUTY1:  duty_reload_one_ff     <= wdata;
        ADDR_DUTY2:  duty_reload_two_ff     <= wdata;
        default: begin
        end
      endcase
    end
  end

  // Output enable, level and mode bits
  always_ff @(posedge clock) begin
    if (reset) begin
      out_en_ff  <= 3'h0;
      out_lvl_ff <= 3'h0;
      out_mod_ff <= 3'h0;
    end else if (wr_out_ctrl) begin
      out_en_ff <= wdata[OUT_EN_LSB +: 3];
      if (!running_ff) begin
        out_lvl_ff <= wdata[OUT_LVL_LSB +: 3];
        out_mod_ff <= wdata[OUT_MOD_LSB +: 3];
      end
    end
  end

  // Master pin, software level only
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_m_ff <= 1'b0;
    end else if (wr_out_ctrl && !(running_ff && out_en_ff[0])) begin
      pin_m_ff <= wdata[OUT_VAL_LSB];
    end
  end

  // Slave one pin, software level or duty
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_s1_ff <= 1'b0;
    end else if (wr_out_ctrl && !(running_ff && out_en_ff[1])) begin
      pin_s1_ff <= wdata[OUT_VAL_LSB + 1];
    end else if (running_ff && out_en_ff[1] && out_mod_ff[1]) begin
      pin_s1_ff <= out_level(act1, out_lvl_ff[1]);
    end
  end

  // Slave two pin, software level or duty
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_s2_ff <= 1'b0;
    end else if (wr_out_ctrl && !(running_ff && out_en_ff[2])) begin
      pin_s2_ff <= wdata[OUT_VAL_LSB + 2];
    end else if (running_ff && out_en_ff[2] && out_mod_ff[2]) begin
      pin_s2_ff <= out_level(act2, out_lvl_ff[2]);
    end
  end

  assign out_val               = {pin_s2_ff, pin_s1_ff, pin_m_ff};
  assign channel_enable_status = {3{running_ff}};

  // Run state
  always_ff @(posedge clock) begin
    if (reset || !unit_clock_enable_ff) begin
      running_ff <= 1'b0;
    end else if (stop_req) begin
      running_ff <= 1'b0;
    end else if (start_req) begin
      running_ff <= 1'b1;
    end
  end

  // Start pending until the first master tick
  always_ff @(posedge clock) begin
    if (reset || !unit_clock_enable_ff || stop_req) begin
      start_pend_ff <= 1'b0;
    end else if (start_req && !running_ff) begin
      start_pend_ff <= 1'b1;
    end else if (tick_m) begin
      start_pend_ff <= 1'b0;
    end
  end

  // Master interval counter, mode 000B
  always_ff @(posedge clock) begin
    if (reset) begin
      master_counter_ff <= ZERO16;
    end else if (master_step) begin
      if (start_pend_ff) begin
        master_counter_ff <= period_reload_value_ff;
      end else if (master_counter_ff == ZERO16) begin
        master_counter_ff <= period_reload_value_ff;
      end else begin
        master_counter_ff <= master_counter_ff - 16'h0001;
      end
    end
  end

  // Master period interrupt, one cycle
  always_ff @(posedge clock) begin
    if (reset || !master_step) begin
      m_irq <= 1'b0;
    end else if (start_pend_ff) begin
      m_irq <= mode_m_ff[MODE_MD0_BIT];
    end else begin
      m_irq <= (master_counter_ff == ZERO16);
    end
  end

  mpwm_slave #(.WIDTH(WIDTH)) u_slave_one (
    .clock   (clock),
    .reset   (reset),
    .running (running_ff),
    .tick    (tick_s1),
    .trigger (m_irq),
    .duty    (duty_reload_one_ff),
    .period  (period_reload_value_ff),
    .count   (slave_counter_one),
    .irq     (s1_irq),
    .active  (act1),
    .busy    (busy1)
  );

  mpwm_slave #(.WIDTH(WIDTH)) u_slave_two (
    .clock   (clock),
    .reset   (reset),
    .running (running_ff),
    .tick    (tick_s2),
    .trigger (m_irq),
    .duty    (duty_reload_two_ff),
    .period  (period_reload_value_ff),
    .count   (slave_counter_two),
    .irq     (s2_irq),
    .active  (act2),
    .busy    (busy2)
  );

  assign master_period_irq    = m_irq;
  assign slave_one_irq        = s1_irq;
  assign slave_two_irq        = s2_irq;
  assign master_output_pin    = pin_m_ff;
  assign slave_one_output_pin = pin_s1_ff;
  assign slave_two_output_pin = pin_s2_ff;

  // Read select
  always_comb begin
    case (addr)
      ADDR_UNIT_CTRL: rd_mux = {15'h0000, unit_clock_enable_ff};
      ADDR_PRESCALE:  rd_mux = {8'h00, clock_prescaler_select_ff};
      ADDR_MODE_M:    rd_mux = {mode_m_ff[15:12], 1'b0, mode_m_ff[10:0]};
      ADDR_MODE_S1:   rd_mux = mode_s1_ff;
      ADDR_MODE_S2:   rd_mux = mode_s2_ff;
      ADDR_PERIOD:    rd_mux = period_reload_value_ff;
      ADDR_DUTY1:     rd_mux = duty_reload_one_ff;
      ADDR_DUTY2:     rd_mux = duty_reload_two_ff;
      ADDR_OUT_CTRL:  rd_mux = {1'b0, out_mod_ff, 1'b0, out_lvl_ff, 1'b0, out_en_ff, 1'b0, out_val};
      ADDR_STATUS:    rd_mux = {11'h000, busy2, busy1, channel_enable_status};
      ADDR_CNT_M:     rd_mux = master_counter_ff;
      ADDR_CNT_S1:    rd_mux = slave_counter_one;
      ADDR_CNT_S2:    rd_mux = slave_counter_two;
      default:        rd_mux = ZERO16;
    endcase
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= ZERO16;
    end else if (rd_en) begin
      rdata <= rd_mux;
    end
  end
endmodule

// ### mpwm_top_sva.sv
`timescale 1ns/1ps
module mpwm_top_sva #(
  parameter int WIDTH = 16
) (
  input wire logic                        clock,
  input wire logic                        reset,
  input wire logic [mpwm_pkg::ADDR_W-1:0] addr,
  input wire logic [15:0]                 wdata,
  input wire logic                        wr_en,
  input wire logic                        rd_en,
  input wire logic [15:0]                 rdata,
  input wire logic                        master_output_pin,
  input wire logic                        slave_one_output_pin,
  input wire logic                        slave_two_output_pin,
  input wire logic                        master_period_irq,
  input wire logic                        slave_one_irq,
  input wire logic                        slave_two_irq
);
  import mpwm_pkg::*;
  logic       unit_on_ff;
  logic       running_ff;
  logic [2:0] out_val;
  assign out_val = wdata[2:0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Unit clock enable as software last wrote it
  always_ff @(posedge clock) begin
    if (reset) begin
      unit_on_ff <= 1'b0;
    end else if (wr_en && addr == ADDR_UNIT_CTRL) begin
      unit_on_ff <= wdata[0];
    end
  end
  // Channels running between start and stop
  always_ff @(posedge clock) begin
    if (reset || !unit_on_ff) begin
      running_ff <= 1'b0;
    end else if (wr_en && unit_on_ff && addr == ADDR_START && wdata[0]) begin
      running_ff <= 1'b1;
    end else if (wr_en && unit_on_ff && addr == ADDR_STOP && wdata[0]) begin
      running_ff <= 1'b0;
    end
  end
  a_reset_clears: assert property (disable iff (1'b0) reset |=> rdata == ZERO16 && !master_output_pin &&
    !slave_one_output_pin && !slave_two_output_pin && !master_period_irq && !slave_one_irq && !slave_two_irq)
    else $error("outputs not cleared by reset");
  a_rdata_holds: assert property (!$past(rd_en) |-> $stable(rdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (rd_en && addr == 4'hF |=> rdata == ZERO16)
    else $error("unmapped read not zero");
  a_master_bit_fixed: assert property (rd_en && addr == ADDR_MODE_M |=> !rdata[MODE_MASTER_BIT])
    else $error("master select bit of channel zero not fixed");
  a_off_frozen: assert property ((!unit_on_ff)[*3] |-> $stable(slave_one_output_pin) &&
    $stable(slave_two_output_pin) && !master_period_irq)
    else $error("activity while unit clock off");
  a_master_pin_static: assert property (!$past(wr_en) |-> $stable(master_output_pin))
    else $error("master pin moved without a write");
  a_stopped_hold: assert property ((!running_ff)[*3] ##0 !$past(wr_en) |->
    $stable(slave_one_output_pin) && $stable(slave_two_output_pin))
    else $error("slave pin moved while stopped");
  a_stopped_write: assert property (wr_en && addr == ADDR_OUT_CTRL && unit_on_ff && !running_ff |=>
    {slave_two_output_pin, slave_one_output_pin, master_output_pin} == $past(out_val))
    else $error("stopped output write not applied");
  a_idle_no_irq: assert property ((!running_ff)[*3] |-> !master_period_irq && !slave_one_irq &&
    !slave_two_irq)
    else $error("interrupt while stopped");
  a_slave_irq_ends: assert property (slave_one_irq |-> ##[0:1] !slave_one_output_pin)
    else $error("slave pin active after its interrupt");
endmodule
bind mpwm_top mpwm_top_sva #(.WIDTH(WIDTH)) u_sva (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .master_output_pin(master_output_pin),
  .slave_one_output_pin(slave_one_output_pin), .slave_two_output_pin(slave_two_output_pin),
  .master_period_irq(master_period_irq), .slave_one_irq(slave_one_irq), .slave_two_irq(slave_two_irq));

// ### tb_top.sv
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
  import mpwm_pkg::*;
  logic        clock;
  logic        reset;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] rdata;
  logic        m_pin;
  logic        s1_pin;
  logic        s2_pin;
  logic        m_irq;
  logic        s1_irq;
  logic        s2_irq;
  logic [2:0]  held;
  int          fail_count;
  int          samples_checked;
  int          span;
  int          hi1;
  int          hi2;
  int          n1;
  int          n2;
  mpwm_top #(.WIDTH(16)) dut (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .master_output_pin(m_pin), .slave_one_output_pin(s1_pin),
    .slave_two_output_pin(s2_pin), .master_period_irq(m_irq), .slave_one_irq(s1_irq), .slave_two_irq(s2_irq));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string nm);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    `CHECK(nm, exp, rdata)
  endtask
  // Counts cycles up to the next period interrupt and the pin activity on the way
  task automatic window(output int sp, output int h1, output int h2, output int c1);
    sp = 0;
    h1 = 0;
    h2 = 0;
    c1 = 0;
    n2 = 0;
    do begin
      @(posedge clock);
      #1;
      sp++;
      h1 += int'(s1_pin === 1'b1);
      h2 += int'(s2_pin === 1'b1);
      c1 += int'(s1_irq === 1'b1);
      n2 += int'(s2_irq === 1'b1);
    end while (m_irq !== 1'b1 && sp < 200);
    if (sp >= 200) begin
      fail_count++;
      summarize();
    end
  endtask
  initial begin
    reset = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    wr(ADDR_PERIOD, 16'h0005);
    wr(ADDR_OUT_CTRL, 16'h6062);
    rd_chk(ADDR_PERIOD, ZERO16, "period while off");
    `CHECK("pin while off", 1'b0, s1_pin)
    wr(ADDR_UNIT_CTRL, 16'h0001);
    rd_chk(ADDR_STATUS, ZERO16, "status");
    rd_chk(4'hF, ZERO16, "unmapped");
    wr(ADDR_PRESCALE, 16'h0011);
    wr(ADDR_MODE_M, 16'h0801);
    rd_chk(ADDR_MODE_M, 16'h0001, "mode master");
    wr(ADDR_MODE_S1, 16'h0000);
    wr(ADDR_MODE_S2, 16'h8000);
    rd_chk(ADDR_MODE_S2, 16'h8000, "mode slave two");
    wr(ADDR_PERIOD, 16'h0003);
    wr(ADDR_DUTY1, 16'h0002);
    wr(ADDR_DUTY2, 16'h0009);
    wr(ADDR_OUT_CTRL, 16'h6062);
    #1;
    `CHECK("initial levels", 3'b010, {s2_pin, s1_pin, m_pin})
    repeat (10) @(posedge clock);
    #1;
    `CHECK("levels held", 3'b010, {s2_pin, s1_pin, m_pin})
    wr(ADDR_OUT_CTRL, 16'h6060);
    $display("test setup done");
    wr(ADDR_START, 16'h0001);
    window(span, hi1, hi2, n1);
    `CHECK("start irq", 1'b1, span <= 2)
    window(span, hi1, hi2, n1);
    `CHECK("period", 8, span)
    window(span, hi1, hi2, n1);
    `CHECK("period again", 8, span)
    `CHECK("duty one", 4, hi1)
    `CHECK("duty two full", 8, hi2)
    `CHECK("slave irq", 1, n1)
    `CHECK("slave two irq", 0, n2)
    $display("test run done");
    wr(ADDR_PERIOD, 16'h0005);
    wr(ADDR_DUTY1, 16'h0003);
    window(span, hi1, hi2, n1);
    `CHECK("old period kept", 4, span)
    window(span, hi1, hi2, n1);
    `CHECK("new period", 12, span)
    `CHECK("new duty", 6, hi1)
    $display("test reload done");
    wr(ADDR_STOP, 16'h0001);
    repeat (3) @(posedge clock);
    #1;
    held = {s2_pin, s1_pin, m_pin};
    repeat (20) @(posedge clock);
    #1;
    `CHECK("stopped levels", held, {s2_pin, s1_pin, m_pin})
    $display("test stop done");
    summarize();
  end
endmodule
